// file: hdl/tbpwm_pkg.sv
// package: register map, field layout, reset values and carriers of the timer based pwm block
package tbpwm_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses on the apb side)
   // ---------------------------------------------------------------
   localparam int         TBPWM_AW        = 12;
   localparam logic [11:0] ADDR_PERIOD    = 12'h000;
   localparam logic [11:0] ADDR_TCTRL     = 12'h004;
   localparam logic [11:0] ADDR_TCOUNT    = 12'h008;
   localparam logic [11:0] ADDR_PINDIR    = 12'h00c;
   localparam logic [11:0] ADDR_LATCH     = 12'h010;
   localparam logic [3:0]  CH_FIRST_SLOT  = 4'h2;     // channel n sits at 0x020 + n*0x010
   localparam logic [3:0]  OFS_CTRL       = 4'h0;
   localparam logic [3:0]  OFS_DCH        = 4'h4;
   localparam logic [3:0]  OFS_DCL        = 4'h8;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_EN_POS   = 7;
   localparam int CTRL_OE_POS   = 6;
   localparam int CTRL_OUT_POS  = 5;
   localparam int CTRL_POL_POS  = 4;
   localparam int DCL_LSB_POS   = 6;
   localparam int TCTRL_ON_POS  = 2;
   localparam int TCTRL_PS_LSB  = 0;
   localparam int TCTRL_OPS_LSB = 3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [1:0] PSEL_RST   = 2'h0;
   localparam logic [3:0] POSTS_RST  = 4'h0;
   localparam logic [7:0] TCOUNT_RST = 8'h00;
   localparam logic [7:0] DCH_RST    = 8'h00;
   localparam logic [1:0] DCL_RST    = 2'h0;

   // ---------------------------------------------------------------
   // prescaler terminal counts (divide by 1, 4, 64)
   // ---------------------------------------------------------------
   localparam logic [5:0] PSC_MAX_1  = 6'h00;
   localparam logic [5:0] PSC_MAX_4  = 6'h03;
   localparam logic [5:0] PSC_MAX_64 = 6'h3f;
   localparam logic [1:0] SUB_LAST   = 2'h3;

   // per channel state
   typedef struct packed {
      logic       en;        // channel_enable_bit
      logic       oe;        // output_drive_enable
      logic       pol;       // polarity_select
      logic [7:0] dch;       // duty_high_reg holding copy
      logic [1:0] dcl;       // duty_low_reg holding copy
      logic [9:0] duty_buf;  // active compare value
      logic       wave;      // raw waveform, 1 = active
   } tbpwm_chan_s;

   // apb request seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tbpwm_apb_req_s;

endpackage : tbpwm_pkg

// file: hdl/tbpwm_top.sv
// timer based pwm generator with apb register access
// How it works
// RULE1: one shared period, per-channel duty compare
// RULE2: outputs go active when timer clears; the code leaves a channel with duty 0 inactive
// RULE3: clear output when base equals 10-bit duty
// RULE4: duty at or above period never clears
// RULE5: duty double buffered, loaded at period match
// RULE6: match increment clears timer, sets, reloads
// RULE7: polarity bit inverts channel output
// RULE8: period is (period+1) x 4 x prescale clocks
// RULE9: postscaler never affects the waveform
// RULE10: base is timer count plus two sub bits
// RULE11: duty writes never disturb running period
// RULE12: software writes both duty halves before match
// RULE13: resolution follows period register value
// RULE14: sleep freezes timer and channel state
// RULE15: pin muxed with latch, driven if output
// RULE16: clearing drive enable returns pin to latch
// RULE17: oversize pulse width leaves pin unchanged
// RULE18: enable bit at control bit 7
// RULE19: read-only output value at control bit 5
// RULE20: reset makes pins inputs, registers reset
// RULE21: disabled channel holds inactive, ignores compare
module tbpwm_top
   import tbpwm_pkg::*;
#(
   parameter int NCH = 2
) (
   input  wire logic              pclk,         // system clock, 200 mhz
   input  wire logic              presetn,      // async reset, active low
   input  wire logic              psel,         // apb select
   input  wire logic              penable,      // apb enable
   input  wire logic              pwrite,       // apb direction, 1 = write
   input  wire logic [11:0]       paddr,        // apb byte address
   input  wire logic [31:0]       pwdata,       // apb write data
   output logic      [31:0]       prdata,       // apb read data
   output logic                   pready,       // apb ready
   output logic                   pslverr,      // apb error, unmapped address
   input  wire logic              sleep_req,    // device sleep, asynchronous
   output logic      [NCH-1:0]    pin_out,      // pin output level
   output logic      [NCH-1:0]    pin_oe        // pin output enable, high = driving
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]             sleep_sync;
      logic [7:0]             period;
      logic [1:0]             psel_code;
      logic [3:0]             posts;
      logic                   tmr_on;
      logic [7:0]             tcount;
      logic [1:0]             sub;
      logic [5:0]             psc;
      logic [NCH-1:0]         pin_dir;      // 1 = input
      logic [NCH-1:0]         latch;
      tbpwm_chan_s [NCH-1:0]  ch;
      logic [31:0]            rdata;
      logic                   ready;
      logic                   err;
      logic [NCH-1:0]         pout;
      logic [NCH-1:0]         poe;
   } tbpwm_state_s;

   tbpwm_state_s   s_q;
   tbpwm_state_s   s_d;
   tbpwm_apb_req_s req;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   localparam tbpwm_state_s STATE_RST = '{
      sleep_sync: 2'h0,
      period:     PERIOD_RST,
      psel_code:  PSEL_RST,
      posts:      POSTS_RST,
      tmr_on:     1'b0,
      tcount:     TCOUNT_RST,
      sub:        2'h0,
      psc:        6'h00,
      pin_dir:    '1,
      latch:      '0,
      ch:         '{default: '{en: 1'b0, oe: 1'b0, pol: 1'b0, dch: DCH_RST,
                               dcl: DCL_RST, duty_buf: 10'h000, wave: 1'b0}},
      rdata:      32'h0000_0000,
      ready:      1'b0,
      err:        1'b0,
      pout:       '0,
      poe:        '0
   };

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic        asleep;
      logic        setup;
      logic        wr;
      logic        glob;
      logic [3:0]  slot;
      logic [3:0]  idx;
      logic        ch_hit;
      logic [5:0]  psc_max;
      logic        inc;
      logic        wrap;
      logic [9:0]  base;
      logic [31:0] rd;
      logic        hit;
      logic [9:0]  nbuf;

      s_d    = s_q;
      asleep = s_q.sleep_sync[1];
      setup  = req.psel & ~req.penable;
      wr     = req.psel & req.penable & s_q.ready & req.pwrite;
      glob   = (req.paddr[11:5] == 7'h00) && (req.paddr[1:0] == 2'h0);
      slot   = req.paddr[7:4];
      idx    = slot - CH_FIRST_SLOT;
      ch_hit = (req.paddr[11:8] == 4'h0) && (slot >= CH_FIRST_SLOT)
               && (32'(idx) < NCH)
               && ((req.paddr[3:0] == OFS_CTRL) || (req.paddr[3:0] == OFS_DCH)
                   || (req.paddr[3:0] == OFS_DCL));
      rd     = 32'h0000_0000;
      hit    = 1'b1;
      psc_max = PSC_MAX_1;
      inc     = 1'b0;
      wrap    = 1'b0;
      base    = 10'h000;
      nbuf    = 10'h000;

      s_d.sleep_sync = {s_q.sleep_sync[0], sleep_req};
      s_d.ready      = 1'b1;

      // ---------------------------------------------------------------
      // read path: data prepared in the setup cycle, answered with no wait
      // ---------------------------------------------------------------
      if (ch_hit) begin
         case (req.paddr[3:0])
            OFS_CTRL: begin
               rd[CTRL_EN_POS]  = s_q.ch[idx].en;                        // RULE18
               rd[CTRL_OE_POS]  = s_q.ch[idx].oe;
               rd[CTRL_OUT_POS] = s_q.ch[idx].wave ^ s_q.ch[idx].pol;    // RULE19
               rd[CTRL_POL_POS] = s_q.ch[idx].pol;
            end
            OFS_DCH: rd[7:0] = s_q.ch[idx].dch;
            OFS_DCL: rd[DCL_LSB_POS +: 2] = s_q.ch[idx].dcl;
            default: hit = 1'b0;
         endcase
      end else if (glob) begin
         case (req.paddr)
            ADDR_PERIOD: rd[7:0] = s_q.period;
            ADDR_TCTRL: begin
               rd[TCTRL_PS_LSB +: 2]  = s_q.psel_code;
               rd[TCTRL_ON_POS]       = s_q.tmr_on;
               rd[TCTRL_OPS_LSB +: 4] = s_q.posts;
            end
            ADDR_TCOUNT: rd[7:0] = s_q.tcount;
            ADDR_PINDIR: rd[NCH-1:0] = s_q.pin_dir;
            ADDR_LATCH:  rd[NCH-1:0] = s_q.latch;
            default:     hit = 1'b0;
         endcase
      end else begin
         hit = 1'b0;
      end

      if (setup) begin
         s_d.rdata = hit ? rd : 32'h0000_0000;
         s_d.err   = ~hit;
      end

      // ---------------------------------------------------------------
      // time base: prescaler, two sub bits, 8-bit timer count
      // ---------------------------------------------------------------
      // the postscaler field is stored for software only            RULE9
      case (s_q.psel_code)
         2'h0:    psc_max = PSC_MAX_1;
         2'h1:    psc_max = PSC_MAX_4;
         default: psc_max = PSC_MAX_64;
      endcase

      inc  = s_q.tmr_on & ~asleep & (s_q.psc >= psc_max);           // RULE14
      wrap = inc && (s_q.sub == SUB_LAST) && (s_q.tcount == s_q.period); // RULE8
      base = {s_q.tcount, s_q.sub};

      if (s_q.tmr_on && !asleep) begin
         s_d.psc = inc ? 6'h00 : s_q.psc + 6'h01;
      end
      if (inc) begin
         s_d.sub = s_q.sub + 2'h1;                                    // RULE10
         if (s_q.sub == SUB_LAST) begin
            s_d.tcount = wrap ? 8'h00 : s_q.tcount + 8'h01;           // RULE6
         end
         base = {s_d.tcount, s_d.sub};
      end

      // ---------------------------------------------------------------
      // channels
      // ---------------------------------------------------------------
      for (int i = 0; i < NCH; i++) begin
         nbuf = {s_q.ch[i].dch, s_q.ch[i].dcl};
         if (!s_q.ch[i].en) begin
            s_d.ch[i].wave = 1'b0;                                    // RULE21
         end else if (wrap) begin
            s_d.ch[i].duty_buf = nbuf;                                // RULE5
            s_d.ch[i].wave     = (nbuf != 10'h000);                   // RULE2 RULE6
         end else if (inc && (base == s_q.ch[i].duty_buf)) begin
            // a duty past {period,2'b11} never matches, so the pin stays  RULE4 RULE17
            s_d.ch[i].wave = 1'b0;                                    // RULE1 RULE3 RULE13
         end
         if (wrap && !s_q.ch[i].en) begin
            s_d.ch[i].duty_buf = nbuf;
         end
      end

      // ---------------------------------------------------------------
      // register writes, taken at the access edge
      // ---------------------------------------------------------------
      // duty writes land in holding copies only                      RULE11
      if (wr && hit) begin
         if (ch_hit) begin
            case (req.paddr[3:0])
               OFS_CTRL: begin
                  s_d.ch[idx].en  = req.pwdata[CTRL_EN_POS];
                  s_d.ch[idx].oe  = req.pwdata[CTRL_OE_POS];
                  s_d.ch[idx].pol = req.pwdata[CTRL_POL_POS];
               end
               OFS_DCH: s_d.ch[idx].dch = req.pwdata[7:0];
               OFS_DCL: s_d.ch[idx].dcl = req.pwdata[DCL_LSB_POS +: 2];
               default: ;
            endcase
         end else begin
            case (req.paddr)
               ADDR_PERIOD: s_d.period = req.pwdata[7:0];
               ADDR_TCTRL: begin
                  s_d.psel_code = req.pwdata[TCTRL_PS_LSB +: 2];
                  s_d.tmr_on    = req.pwdata[TCTRL_ON_POS];
                  s_d.posts     = req.pwdata[TCTRL_OPS_LSB +: 4];
               end
               ADDR_TCOUNT: begin
                  // a count write restarts the sub bits and the prescaler
                  s_d.tcount = req.pwdata[7:0];
                  s_d.sub    = 2'h0;
                  s_d.psc    = 6'h00;
               end
               ADDR_PINDIR: s_d.pin_dir = req.pwdata[NCH-1:0];
               ADDR_LATCH:  s_d.latch   = req.pwdata[NCH-1:0];
               default: ;
            endcase
         end
      end

      // ---------------------------------------------------------------
      // pins: generator or port latch, driven only when set as output
      // ---------------------------------------------------------------
      for (int i = 0; i < NCH; i++) begin
         if (s_q.ch[i].oe) begin
            s_d.pout[i] = s_q.ch[i].wave ^ s_q.ch[i].pol;             // RULE7 RULE15
         end else begin
            s_d.pout[i] = s_q.latch[i];                               // RULE16
         end
         s_d.poe[i] = ~s_q.pin_dir[i];                                // RULE15
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= STATE_RST;                                            // RULE20
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.rdata;
   assign pready  = s_q.ready;
   assign pslverr = s_q.err;
   assign pin_out = s_q.pout;
   assign pin_oe  = s_q.poe;

endmodule // tbpwm_top

// file: dv/tbpwm_load.sv
// model of the external load: counts the cycles each pin sits high
module tbpwm_load
   import tbpwm_pkg::*;
#(
   parameter int NCH = 2
) (
   input  wire logic           pclk,    // system clock
   input  wire logic           clr,     // restart the counts
   input  wire logic [NCH-1:0] pin_out, // pin level driven
   input  wire logic [NCH-1:0] pin_oe,  // pin driven
   output int                  hi_cnt [NCH] // high cycles since clr
);
   logic [NCH-1:0] lvl;
   // a released pin sits at the load's pull-down, never at a stale level
   assign lvl = pin_out & pin_oe;
   always @(posedge pclk)
      for (int i = 0; i < NCH; i++)
         hi_cnt[i] <= clr ? 0 : hi_cnt[i] + int'(lvl[i] === 1'b1);
endmodule // tbpwm_load

// file: dv/tbpwm_sva.sv
// checker: bus answer and pin timing properties of the pwm block
module tbpwm_sva
   import tbpwm_pkg::*;
#(
   parameter int NCH = 2
) (
   input wire logic           pclk,    // clock
   input wire logic           presetn, // reset, active low
   input wire logic           psel,    // apb select
   input wire logic           penable, // apb enable
   input wire logic           pwrite,  // apb direction
   input wire logic [11:0]    paddr,   // apb address
   input wire logic [31:0]    pwdata,  // apb write data
   input wire logic [31:0]    prdata,  // apb read data
   input wire logic           pready,  // apb ready
   input wire logic           pslverr, // apb error
   input wire logic           sleep_req, // sleep
   input wire logic [NCH-1:0] pin_out, // pin level
   input wire logic [NCH-1:0] pin_oe   // pin enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic hit;
   assign acc = psel && penable;
   assign hit = (paddr[1:0] == 2'h0) && (paddr <= ADDR_LATCH || (paddr[11:4] >= 8'h02
                && paddr[11:4] < 8'(NCH + 2) && paddr[3:0] <= 4'h8));
   a_ready_up: assert property ($past(presetn) |-> pready)
      else $error("pready low after reset release");
   a_map_ok: assert property (acc && hit |-> !pslverr)
      else $error("error on a mapped register");
   a_map_err: assert property (acc && !hit |-> pslverr)
      else $error("no error on an unmapped address");
   a_err_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   a_rd_hold: assert property (acc |=> $stable(prdata))
      else $error("read data moved outside a setup cycle");
   a_pin_rst: assert property ($rose(presetn) |-> (pin_oe == '0)[*2])
      else $error("pin driven right after reset");
   a_dir_cause: assert property ($changed(pin_oe) |->
                                 $past(acc && pwrite && paddr == ADDR_PINDIR, 2))
      else $error("pin enable moved without a direction write");
   a_sleep_hold: assert property ((sleep_req && !psel)[*7] |-> $stable(pin_out))
      else $error("pin changed while asleep");
   c_unmapped: cover property (acc && !hit);
   c_sleep: cover property (sleep_req [*8]);
   c_wave: cover property ($rose(pin_out[1]) && pin_oe[1]);
endmodule // tbpwm_sva

bind tbpwm_top tbpwm_sva #(.NCH(NCH)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .pin_out(pin_out),
   .pin_oe(pin_oe));

// file: dv/tbpwm_test.sv
// testbench: register access, waveform timing, sleep and reset of the pwm block
module tbpwm_test
   import tbpwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NCH = 2;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0, clr = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h0000624a;
   logic pready, pslverr, err, pol;
   logic [NCH-1:0] pin_out, pin_oe;
   int hi_cnt [NCH];
   int n_fail = 0, compares = 0, p, code, d [2];
   int cp [4] = '{0, 0, 3, 255};
   int cd [4] = '{0, 2, 17, 1023};
   always #2.5 pclk = ~pclk;
   tbpwm_top #(.NCH(NCH)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .pin_out(pin_out),
      .pin_oe(pin_oe));
   tbpwm_load #(.NCH(NCH)) u_load (.pclk(pclk), .clr(clr), .pin_out(pin_out),
      .pin_oe(pin_oe), .hi_cnt(hi_cnt));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] cha(int n, logic [3:0] ofs);
      return {4'h0, CH_FIRST_SLOT + 4'(n), ofs};
   endfunction
   // high cycles of one period: duty 0 never rises, oversize duty never falls
   function automatic int exp_hi(int p, int d, int ps, logic pol);
      int n;
      int h;
      n = 4 * (p + 1) * ps;
      h = (d * ps < n) ? d * ps : n;
      return pol ? n - h : h;
   endfunction
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] dat);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] dat);
      apb(1'b1, a, dat);
   endtask
   task automatic rdchk(logic [11:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check("register read", exp, rd);
   endtask
   task automatic measure(int p, int d [2], int code, logic pol);
      int ps;
      int n;
      ps = (code == 0) ? 1 : (code == 1) ? 4 : 64;
      n = 4 * (p + 1) * ps;
      // two periods so the new duty has been reloaded before counting
      repeat (2 * n + 4) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (n + 1) @(posedge pclk);
      for (int c = 0; c < NCH; c++)
         check("high time", 32'(exp_hi(p, d[c], ps, pol ^ (c != 0))), 32'(hi_cnt[c]));
   endtask
   task automatic results();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400_000;
      n_fail++;
      results();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(ADDR_PERIOD, {24'h0, PERIOD_RST});
      wr(ADDR_PINDIR, 32'h0);
      @(posedge pclk);
      check("pins driven", 32'h3, 32'(pin_oe));
      for (int i = 0; i < 8; i++) begin
         p = (i < 4) ? cp[i] : int'(xs() % 8);
         d[0] = (i < 4) ? cd[i] : int'(xs() % (4 * p + 6));
         d[1] = (d[0] + 3) % (4 * p + 6);
         code = (i < 4) ? 0 : i % 3;
         v = xs();
         pol = v[0];
         wr(ADDR_PERIOD, 32'(p));
         wr(ADDR_TCOUNT, 32'h0);
         wr(ADDR_TCTRL, (v & 32'h78) | 32'h4 | 32'(code));
         for (int c = 0; c < NCH; c++) begin
            wr(cha(c, OFS_CTRL), 32'hc0 | (32'(pol ^ (c != 0)) << 4));
            wr(cha(c, OFS_DCH), 32'(d[c] >> 2));
            wr(cha(c, OFS_DCL), 32'(d[c] & 3) << 6);
         end
         measure(p, d, code, pol);
      end
      for (int b = 0; b < 2; b++) begin
         wr(cha(1, OFS_CTRL), 32'h20 | 32'(b << 4));
         rdchk(cha(1, OFS_CTRL), b ? 32'h30 : 32'h0);
      end
      wr(cha(0, OFS_CTRL), 32'h80);
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_LATCH, 32'(b));
         @(posedge pclk);
         check("latch pin", 32'(b), 32'(pin_out[0]));
      end
      apb(1'b0, 12'h014, 32'h0);
      check("unmapped error", 32'h1, 32'(err));
      check("unmapped data", 32'h0, rd);
      wr(cha(1, OFS_CTRL), 32'hc0);
      wr(ADDR_PERIOD, 32'h0000_00ff);
      wr(ADDR_TCTRL, 32'h4);
      sleep_req <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, ADDR_TCOUNT, 32'h0);
      v = rd;
      repeat (40) @(posedge pclk);
      rdchk(ADDR_TCOUNT, v);
      sleep_req <= 1'b0;
      repeat (12) @(posedge pclk);
      apb(1'b0, ADDR_TCOUNT, 32'h0);
      check("count resumes", 32'h1, 32'((rd != v) === 1'b1));
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      check("pins released", 32'h0, 32'(pin_oe));
      presetn <= 1'b1;
      apb(1'b0, ADDR_PINDIR, 32'h0);
      check("direction reset", 32'h3, rd & 32'h3);
      rdchk(cha(0, OFS_DCL), 32'h0);
      results();
   end
endmodule // tbpwm_test
